// *** blink_sequencer.sv ***
// Pulse-burst blink generator: N pulses of on/off time, then an optional gap.
`timescale 1ns/1ps
module blink_sequencer #(
   parameter int unsigned CNT_W = 28
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic restart,
   input wire logic [status_indicator_pkg::PCNT_W-1:0] pulseCount,
   input wire logic [CNT_W-1:0] onCycles,
   input wire logic [CNT_W-1:0] offCycles,
   input wire logic [CNT_W-1:0] gapCycles,
   output logic lampOn
);

   status_indicator_pkg::blink_phase_t phase_r;
   logic [CNT_W-1:0] cnt_r;
   logic [status_indicator_pkg::PCNT_W-1:0] pulseIdx_r;
   logic lamp_r;
   logic phaseDone;
   logic lastPulse;

   if (CNT_W < 2) begin : g_bad_width
      $error("blink_sequencer: CNT_W too small");
   end

   assign lampOn = lamp_r;

   always_comb begin
      case (phase_r)
         status_indicator_pkg::PH_ON: phaseDone = (cnt_r == onCycles - 1'b1);
         status_indicator_pkg::PH_OFF: phaseDone = (cnt_r == offCycles - 1'b1);
         status_indicator_pkg::PH_GAP: phaseDone = (cnt_r == gapCycles - 1'b1);
         default: phaseDone = 1'b1;
      endcase
   end

   assign lastPulse = (pulseIdx_r == pulseCount - 1'b1);

   ////////////////////////////////////////////////////////////////////////////////////////////

   // A restart always begins with a lit pulse so a new state shows at once.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase_r <= status_indicator_pkg::PH_ON;
         cnt_r <= '0;
         pulseIdx_r <= '0;
         lamp_r <= 1'b0;
      end else if (restart) begin // see RL9
         phase_r <= status_indicator_pkg::PH_ON;
         cnt_r <= '0;
         pulseIdx_r <= '0;
         lamp_r <= 1'b1;
      end else if (!phaseDone) begin
         cnt_r <= cnt_r + 1'b1;
      end else begin
         cnt_r <= '0;
         case (phase_r)
            status_indicator_pkg::PH_ON: begin
               phase_r <= status_indicator_pkg::PH_OFF;
               lamp_r <= 1'b0;
            end
            status_indicator_pkg::PH_OFF: begin
               if (!lastPulse) begin
                  phase_r <= status_indicator_pkg::PH_ON;
                  pulseIdx_r <= pulseIdx_r + 1'b1;
                  lamp_r <= 1'b1;
               end else if (gapCycles == '0) begin
                  phase_r <= status_indicator_pkg::PH_ON;
                  pulseIdx_r <= '0;
                  lamp_r <= 1'b1;
               end else begin
                  phase_r <= status_indicator_pkg::PH_GAP;
               end
            end
            default: begin
               phase_r <= status_indicator_pkg::PH_ON;
               pulseIdx_r <= '0;
               lamp_r <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   a_pulse_end: assert property (@(posedge clock) disable iff (!rst_b) // see RL1
      (phase_r == status_indicator_pkg::PH_ON) && phaseDone && !restart |=> !lampOn)
      else $error("Lamp stayed lit past the pulse time.");

   a_gap_dark: assert property (@(posedge clock) disable iff (!rst_b) // see RL4
      (phase_r == status_indicator_pkg::PH_GAP) |-> !lampOn)
      else $error("Lamp lit during the gap.");

endmodule

// *** network_node_status_indicator.sv ***
// Node status indicators: network state tracking and activity/error blink patterns.
`timescale 1ns/1ps
module network_node_status_indicator #(
   parameter logic [status_indicator_pkg::TIMER_W-1:0] SETTLE_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::SETTLE_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] LOSS_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::LOSS_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] NORMAL_HALF_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::NORMAL_HALF_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] OFFLINE_HALF_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::OFFLINE_HALF_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] ERROR_HALF_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::ERROR_HALF_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] BURST_ON_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::BURST_ON_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] BURST_OFF_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::BURST_OFF_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] GAP_NO_RX_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::GAP_NO_RX_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] GAP_NO_TOKEN_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::GAP_NO_TOKEN_CYC),
   parameter logic [status_indicator_pkg::TIMER_W-1:0] GAP_DUPLICATE_CYC =
      status_indicator_pkg::TIMER_W'(status_indicator_pkg::GAP_DUPLICATE_CYC)
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic tokenReceived,
   input wire logic tokenSeen,
   input wire logic dupAddrSeen,
   input wire logic lineError,
   input wire logic stationPresent,
   input wire logic addrInvalid,
   output logic activityIndicator,
   output logic errorIndicator,
   output status_indicator_pkg::net_state_t netState
);

   localparam int unsigned TW = status_indicator_pkg::TIMER_W;

   status_indicator_pkg::net_state_t state_r;
   status_indicator_pkg::net_state_t state_nxt;
   logic [TW-1:0] timer_r;
   logic gotToken_r;
   logic sawOther_r;
   logic [TW-1:0] errCnt_r;
   logic errLamp_r;
   logic stateChange;
   logic timerClear;
   logic timerDone;
   logic anyFault;
   logic [status_indicator_pkg::PCNT_W-1:0] pulseCount;
   logic [TW-1:0] onCycles;
   logic [TW-1:0] offCycles;
   logic [TW-1:0] gapCycles;

   if (SETTLE_CYC == '0 || LOSS_CYC == '0 || NORMAL_HALF_CYC == '0 ||
       OFFLINE_HALF_CYC == '0 || ERROR_HALF_CYC == '0 || BURST_ON_CYC == '0 ||
       BURST_OFF_CYC == '0) begin : g_bad_timing
      $error("network_node_status_indicator: timing counts must be nonzero");
   end

   assign netState = state_r;
   assign errorIndicator = errLamp_r;
   assign anyFault = lineError | stationPresent | addrInvalid;
   assign stateChange = (state_nxt != state_r);

   // The timer measures time since state entry; a fresh duplicate or a token hand-off
   // restarts it so that it becomes a quiet-time watchdog in those states.
   always_comb begin
      timerClear = stateChange;
      if (state_r == status_indicator_pkg::NET_DUPLICATE && dupAddrSeen) begin
         timerClear = 1'b1;
      end
      if (state_r == status_indicator_pkg::NET_NORMAL && tokenReceived) begin
         timerClear = 1'b1;
      end
   end

   always_comb begin
      case (state_r)
         status_indicator_pkg::NET_NORMAL: timerDone = (timer_r == LOSS_CYC - 1'b1);
         default: timerDone = (timer_r == SETTLE_CYC - 1'b1);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Network state.

   always_comb begin
      state_nxt = state_r;
      if (dupAddrSeen) begin
         state_nxt = status_indicator_pkg::NET_DUPLICATE; // see RL6
      end else begin
         case (state_r)
            status_indicator_pkg::NET_OFFLINE: begin
               if (timerDone) begin // see RL3
                  if (gotToken_r || tokenReceived) begin
                     state_nxt = status_indicator_pkg::NET_NORMAL;
                  end else if (sawOther_r || tokenSeen) begin
                     state_nxt = status_indicator_pkg::NET_NO_RX;
                  end else begin
                     state_nxt = status_indicator_pkg::NET_NO_TOKEN;
                  end
               end
            end
            status_indicator_pkg::NET_NORMAL: begin
               if (timerDone && !tokenReceived) begin
                  if (sawOther_r || tokenSeen) begin
                     state_nxt = status_indicator_pkg::NET_NO_RX; // see RL4
                  end else begin
                     state_nxt = status_indicator_pkg::NET_NO_TOKEN; // see RL5
                  end
               end
            end
            status_indicator_pkg::NET_NO_RX: begin
               if (tokenReceived) begin
                  state_nxt = status_indicator_pkg::NET_NORMAL;
               end
            end
            status_indicator_pkg::NET_NO_TOKEN: begin
               if (tokenReceived) begin
                  state_nxt = status_indicator_pkg::NET_NORMAL;
               end else if (tokenSeen) begin
                  state_nxt = status_indicator_pkg::NET_NO_RX; // see RL4
               end
            end
            status_indicator_pkg::NET_DUPLICATE: begin
               if (timerDone) begin
                  state_nxt = status_indicator_pkg::NET_OFFLINE; // see RL7
               end
            end
            default: state_nxt = status_indicator_pkg::NET_OFFLINE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= status_indicator_pkg::NET_OFFLINE; // see RL2
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         timer_r <= '0;
      end else if (timerClear) begin
         timer_r <= '0;
      end else if (!timerDone) begin
         timer_r <= timer_r + 1'b1;
      end
   end

   // Token history over the current window; an event in the clearing cycle is kept.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gotToken_r <= 1'b0;
         sawOther_r <= 1'b0;
      end else begin
         gotToken_r <= tokenReceived | (gotToken_r & ~timerClear);
         sawOther_r <= tokenSeen | (sawOther_r & ~timerClear);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Activity pattern per state.

   always_comb begin
      pulseCount = status_indicator_pkg::PULSES_SINGLE;
      onCycles = OFFLINE_HALF_CYC;
      offCycles = OFFLINE_HALF_CYC;
      gapCycles = '0;
      case (state_r)
         status_indicator_pkg::NET_NORMAL: begin
            onCycles = NORMAL_HALF_CYC; // see RL1
            offCycles = NORMAL_HALF_CYC;
         end
         status_indicator_pkg::NET_NO_RX: begin
            pulseCount = status_indicator_pkg::PULSES_NO_RX; // see RL4
            onCycles = BURST_ON_CYC;
            offCycles = BURST_OFF_CYC;
            gapCycles = GAP_NO_RX_CYC;
         end
         status_indicator_pkg::NET_NO_TOKEN: begin
            pulseCount = status_indicator_pkg::PULSES_NO_TOKEN; // see RL5
            onCycles = BURST_ON_CYC;
            offCycles = BURST_OFF_CYC;
            gapCycles = GAP_NO_TOKEN_CYC;
         end
         status_indicator_pkg::NET_DUPLICATE: begin
            pulseCount = status_indicator_pkg::PULSES_DUPLICATE; // see RL6
            onCycles = BURST_ON_CYC;
            offCycles = BURST_OFF_CYC;
            gapCycles = GAP_DUPLICATE_CYC;
         end
         default: begin
            pulseCount = status_indicator_pkg::PULSES_SINGLE; // see RL2
         end
      endcase
   end

   // Restart follows the state change so an old burst never leaks into the new pattern.
   blink_sequencer #(
      .CNT_W(TW)
   ) u_activity (
      .clock(clock),
      .rst_b(rst_b),
      .restart(stateChange), // see RL9
      .pulseCount(pulseCount),
      .onCycles(onCycles),
      .offCycles(offCycles),
      .gapCycles(gapCycles),
      .lampOn(activityIndicator)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Error indicator.

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         errCnt_r <= '0;
         errLamp_r <= 1'b0;
      end else if (!anyFault) begin
         errCnt_r <= '0;
         errLamp_r <= 1'b0;
      end else if (errCnt_r == ERROR_HALF_CYC - 1'b1) begin
         errCnt_r <= '0;
         errLamp_r <= ~errLamp_r; // see RL8
      end else begin
         errCnt_r <= errCnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   a_dup_entry: assert property (@(posedge clock) disable iff (!rst_b) // see RL6
      dupAddrSeen |=> (state_r == status_indicator_pkg::NET_DUPLICATE) && (timer_r == '0))
      else $error("Duplicate address did not enter or rearm the duplicate state.");

   a_dup_exit: assert property (@(posedge clock) disable iff (!rst_b) // see RL7
      (state_r == status_indicator_pkg::NET_DUPLICATE) && (timer_r == SETTLE_CYC - 1'b1)
      && !dupAddrSeen |=> (state_r == status_indicator_pkg::NET_OFFLINE))
      else $error("Duplicate state not left after the quiet time.");

   a_offline_hold: assert property (@(posedge clock) disable iff (!rst_b) // see RL2
      (state_r == status_indicator_pkg::NET_OFFLINE) && (timer_r < SETTLE_CYC - 1'b1)
      && !dupAddrSeen |=> (state_r == status_indicator_pkg::NET_OFFLINE))
      else $error("Offline state left before the listen time.");

   a_offline_exit: assert property (@(posedge clock) disable iff (!rst_b) // see RL3
      (state_r == status_indicator_pkg::NET_OFFLINE) && (timer_r == SETTLE_CYC - 1'b1)
      && !dupAddrSeen |=> (state_r != status_indicator_pkg::NET_OFFLINE))
      else $error("Offline state not left after the listen time.");

   a_normal_keep: assert property (@(posedge clock) disable iff (!rst_b) // see RL1
      (state_r == status_indicator_pkg::NET_NORMAL) && tokenReceived && !dupAddrSeen
      |=> (state_r == status_indicator_pkg::NET_NORMAL) && (timer_r == '0))
      else $error("Token hand-off did not keep normal operation.");

   a_search_seen: assert property (@(posedge clock) disable iff (!rst_b) // see RL5
      (state_r == status_indicator_pkg::NET_NO_TOKEN) && tokenSeen && !tokenReceived
      && !dupAddrSeen |=> (state_r == status_indicator_pkg::NET_NO_RX))
      else $error("Seen token did not move the search state.");

   a_restart_lit: assert property (@(posedge clock) disable iff (!rst_b) // see RL9
      stateChange |=> activityIndicator ##1 (activityIndicator || (onCycles == 1)))
      else $error("Pattern did not restart with a lit pulse.");

   a_err_dark: assert property (@(posedge clock) disable iff (!rst_b) // see RL8
      !anyFault |=> !errorIndicator)
      else $error("Error indicator lit with no fault.");

   a_err_flash: assert property (@(posedge clock) disable iff (!rst_b) // see RL8
      anyFault && (errCnt_r == ERROR_HALF_CYC - 1'b1)
      |=> (errorIndicator != $past(errorIndicator)))
      else $error("Error indicator did not toggle while faulted.");

endmodule

// *** network_node_status_indicator_bench.sv ***
// Self-checking bench for the node status indicator with a token bus model.
`timescale 1ns/1ps
module network_node_status_indicator_bench;
   // Short timing so that every state is reached in a few hundred cycles.
   localparam int SETTLE = 200;
   localparam int LOSS = 60;
   localparam int NORMAL_HALF = 3;
   localparam int OFFLINE_HALF = 8;
   localparam int ERROR_HALF = 4;
   localparam int BURST = 2;
   localparam int GAP_NO_RX = 10;
   localparam int GAP_NO_TOKEN = 9;
   localparam int GAP_DUP = 7;
   localparam int TW = status_indicator_pkg::TIMER_W;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [2:0] faults = 3'h0;
   logic sel = 1'b0;
   logic tokenReceived, tokenSeen, dupAddrSeen;
   logic activityIndicator, errorIndicator;
   status_indicator_pkg::net_state_t netState;
   wire logic lamp = sel ? errorIndicator : activityIndicator;
   int error_cnt = 0;
   int n_compared = 0;

   always #10 clock = ~clock;

   token_bus_model u_token_bus_model (.clock(clock), .mode(mode),
      .tokenReceived(tokenReceived), .tokenSeen(tokenSeen), .dupAddrSeen(dupAddrSeen));

   network_node_status_indicator #(
      .SETTLE_CYC(TW'(SETTLE)), .LOSS_CYC(TW'(LOSS)), .NORMAL_HALF_CYC(TW'(NORMAL_HALF)),
      .OFFLINE_HALF_CYC(TW'(OFFLINE_HALF)), .ERROR_HALF_CYC(TW'(ERROR_HALF)),
      .BURST_ON_CYC(TW'(BURST)), .BURST_OFF_CYC(TW'(BURST)), .GAP_NO_RX_CYC(TW'(GAP_NO_RX)),
      .GAP_NO_TOKEN_CYC(TW'(GAP_NO_TOKEN)), .GAP_DUPLICATE_CYC(TW'(GAP_DUP))
   ) u_network_node_status_indicator (.clock(clock), .rst_b(rst_b),
      .tokenReceived(tokenReceived), .tokenSeen(tokenSeen), .dupAddrSeen(dupAddrSeen),
      .lineError(faults[0]), .stationPresent(faults[1]), .addrInvalid(faults[2]),
      .activityIndicator(activityIndicator), .errorIndicator(errorIndicator),
      .netState(netState));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Waits on falling edges for a state; a wait that runs out ends the run.
   task automatic wait_state(input status_indicator_pkg::net_state_t s, input int limit,
         output int n);
      n = 0;
      while (netState !== s && n < limit) begin
         @(negedge clock);
         n++;
      end
      if (netState !== s) begin
         check("state wait", 32'(netState), 32'(s));
         end_of_test();
      end
   endtask

   // Counts lamp pulses from the entry cycle; the window is shorter than one
   // period under either reading of where the gap begins.
   task automatic count_pulses(input int len, output int rises);
      logic prev;
      prev = lamp;
      rises = (lamp === 1'b1) ? 1 : 0;
      repeat (len - 1) begin
         @(negedge clock);
         if (lamp === 1'b1 && prev === 1'b0) rises++;
         prev = lamp;
      end
   endtask

   task automatic high_run(output int n);
      n = 0;
      while (lamp === 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("reset state", 32'(netState), 32'(status_indicator_pkg::NET_OFFLINE));
      check("reset activity", 32'(activityIndicator), 32'h0);
      check("reset error", 32'(errorIndicator), 32'h0);
      $display("test reset done");
   endtask

   task automatic t_settle();
      int n;
      mode <= 2'h1;
      wait_state(status_indicator_pkg::NET_NORMAL, SETTLE + 50, n);
      check("settle time", 32'(n >= SETTLE - 5 && n <= SETTLE + 5), 32'h1);
      check("normal restart lit", 32'(lamp), 32'h1);
      high_run(n);
      check("normal on time", 32'(n), 32'(NORMAL_HALF));
      repeat (150) @(negedge clock);
      check("normal held", 32'(netState), 32'(status_indicator_pkg::NET_NORMAL));
      $display("test settle done");
   endtask

   task automatic t_no_rx();
      int n;
      mode <= 2'h2;
      wait_state(status_indicator_pkg::NET_NO_RX, LOSS + 40, n);
      count_pulses(2 * 2 * BURST + GAP_NO_RX - 3, n);
      check("no rx pulses", 32'(n), 32'h2);
      $display("test no rx done");
   endtask

   task automatic t_no_token();
      int n;
      mode <= 2'h1;
      wait_state(status_indicator_pkg::NET_NORMAL, 40, n);
      mode <= 2'h0;
      wait_state(status_indicator_pkg::NET_NO_TOKEN, LOSS + 40, n);
      count_pulses(3 * 2 * BURST + GAP_NO_TOKEN - 3, n);
      check("no token pulses", 32'(n), 32'h3);
      mode <= 2'h2;
      wait_state(status_indicator_pkg::NET_NO_RX, 40, n);
      check("token seen", 32'(netState), 32'(status_indicator_pkg::NET_NO_RX));
      $display("test no token done");
   endtask

   task automatic t_duplicate();
      int n;
      mode <= 2'h3;
      wait_state(status_indicator_pkg::NET_DUPLICATE, 10, n);
      check("dup prompt", 32'(n <= 3), 32'h1);
      count_pulses(4 * 2 * BURST + GAP_DUP - 3, n);
      check("dup pulses", 32'(n), 32'h4);
      repeat (280) @(negedge clock);
      check("dup held", 32'(netState), 32'(status_indicator_pkg::NET_DUPLICATE));
      mode <= 2'h0;
      wait_state(status_indicator_pkg::NET_OFFLINE, SETTLE + 20, n);
      check("dup quiet time", 32'(n >= SETTLE - 60 && n <= SETTLE + 10), 32'h1);
      check("offline restart lit", 32'(lamp), 32'h1);
      high_run(n);
      check("offline on time", 32'(n), 32'(OFFLINE_HALF));
      repeat (8) @(negedge clock);
      check("offline held", 32'(netState), 32'(status_indicator_pkg::NET_OFFLINE));
      $display("test duplicate done");
   endtask

   task automatic t_faults();
      int n;
      sel = 1'b1;
      for (int i = 0; i < 3; i++) begin
         faults <= 3'h1 << i;
         n = 0;
         while (errorIndicator !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
         end
         check("error first on", 32'(n), 32'(ERROR_HALF));
         if (n == 20) begin
            end_of_test();
         end
         high_run(n);
         check("error on time", 32'(n), 32'(ERROR_HALF));
         faults <= 3'h0;
         @(negedge clock);
         @(negedge clock);
         check("error off", 32'(errorIndicator), 32'h0);
      end
      sel = 1'b0;
      $display("test faults done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge clock);
      t_reset();
      rst_b <= 1'b1;
      t_settle();
      t_no_rx();
      t_no_token();
      t_duplicate();
      t_faults();
      end_of_test();
   end
endmodule

// *** status_indicator_pkg.sv ***
// Constants, state codes and timing for the network node status indicator.
// Operation
// RL1: normal token rotation: activity blinks six per second
// RL2: offline after power-up or duplicate; blink once/second
// RL3: after five seconds offline, attempt normal operation
// RL4: token seen, never received: two pulses, 2 s gap
// RL5: no token found: three pulses, 1.7 s gap
// RL6: duplicate address: four pulses, 1.4 s gap, hold
// RL7: five seconds without duplicate: back to offline
// RL8: error indicator flashes on any external fault
// RL9: pattern timing from clock, restarts on state change
package status_indicator_pkg;

   localparam int unsigned CLOCK_HZ = 50_000_000;
   localparam int unsigned CYC_PER_MS = CLOCK_HZ / 1000;

   // Times in their own units.
   localparam int unsigned SETTLE_MS = 5000;
   localparam int unsigned LOSS_MS = 1000;
   localparam int unsigned NORMAL_RATE_HZ = 6;
   localparam int unsigned OFFLINE_RATE_HZ = 1;
   localparam int unsigned ERROR_RATE_HZ = 2;
   localparam int unsigned BURST_ON_MS = 100;
   localparam int unsigned BURST_OFF_MS = 100;
   localparam int unsigned GAP_NO_RX_MS = 2000;
   localparam int unsigned GAP_NO_TOKEN_MS = 1700;
   localparam int unsigned GAP_DUPLICATE_MS = 1400;

   // Cycle counts derived from the times.
   localparam int unsigned TIMER_W = 28;
   localparam int unsigned SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
   localparam int unsigned LOSS_CYC = LOSS_MS * CYC_PER_MS;
   localparam int unsigned NORMAL_HALF_CYC = CLOCK_HZ / (2 * NORMAL_RATE_HZ);
   localparam int unsigned OFFLINE_HALF_CYC = CLOCK_HZ / (2 * OFFLINE_RATE_HZ);
   localparam int unsigned ERROR_HALF_CYC = CLOCK_HZ / (2 * ERROR_RATE_HZ);
   localparam int unsigned BURST_ON_CYC = BURST_ON_MS * CYC_PER_MS;
   localparam int unsigned BURST_OFF_CYC = BURST_OFF_MS * CYC_PER_MS;
   localparam int unsigned GAP_NO_RX_CYC = GAP_NO_RX_MS * CYC_PER_MS;
   localparam int unsigned GAP_NO_TOKEN_CYC = GAP_NO_TOKEN_MS * CYC_PER_MS;
   localparam int unsigned GAP_DUPLICATE_CYC = GAP_DUPLICATE_MS * CYC_PER_MS;

   localparam int unsigned PCNT_W = 3;
   localparam logic [PCNT_W-1:0] PULSES_SINGLE = 3'h1;
   localparam logic [PCNT_W-1:0] PULSES_NO_RX = 3'h2;
   localparam logic [PCNT_W-1:0] PULSES_NO_TOKEN = 3'h3;
   localparam logic [PCNT_W-1:0] PULSES_DUPLICATE = 3'h4;

   typedef enum logic [2:0] {
      NET_OFFLINE = 3'b000,
      NET_NORMAL = 3'b001,
      NET_NO_RX = 3'b010,
      NET_NO_TOKEN = 3'b011,
      NET_DUPLICATE = 3'b100
   } net_state_t;

   typedef enum logic [1:0] {
      PH_ON = 2'b00,
      PH_OFF = 2'b01,
      PH_GAP = 2'b10
   } blink_phase_t;

endpackage

// *** token_bus_model.sv ***
// Token bus model: emits token and duplicate-address events for a chosen network condition.
`timescale 1ns/1ps
module token_bus_model #(
   parameter int unsigned TOKEN_GAP = 20,
   parameter int unsigned DUP_GAP = 50
) (
   input wire logic clock,
   input wire logic [1:0] mode,
   output logic tokenReceived,
   output logic tokenSeen,
   output logic dupAddrSeen
);
   // Modes: 0 silent bus, 1 ring that includes us, 2 ring of others only,
   // 3 a peer with our address plus a ring that includes us.
   int unsigned phase = 0;
   logic [1:0] lastMode = 2'h0;

   initial begin
      tokenReceived = 1'b0;
      tokenSeen = 1'b0;
      dupAddrSeen = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Events change on the falling edge so that the block samples them cleanly.
   // Mode 3 raises a token and a duplicate in one cycle on purpose, to show
   // that the duplicate wins.
   always @(negedge clock) begin
      if (mode != lastMode) begin
         phase = 0;
      end else begin
         phase = phase + 1;
      end
      lastMode = mode;
      tokenReceived <= (mode == 2'h1 || mode == 2'h3) && (phase % TOKEN_GAP == 0);
      tokenSeen <= (mode != 2'h0) && (phase % TOKEN_GAP == TOKEN_GAP / 2);
      dupAddrSeen <= (mode == 2'h3) && (phase % DUP_GAP == 0);
   end
endmodule
